// >>> core/msc_core.sv
// Sweep timing, event buffering, SYNC outputs, run line and I/O port.
// Assumes pins arrive asynchronously and software owns the strobes.
`timescale 1ns/1ps
module msc_core (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire msc_pkg::msc_bus_t bus,
  output logic [31:0] rdata,
  input wire logic startPin,
  input wire logic stopPin,
  input wire logic goIn,
  output logic goOut,
  output logic goOe,
  input wire logic [7:0] dioIn,
  output logic [7:0] dioOut,
  output logic [7:0] dioOe,
  output logic sync1,
  output logic sync2
);
  import msc_pkg::*;

  // ----------------------------------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------------------------------
  logic rstMeta;
  logic rstOk;
  logic [10:0] pinMeta;
  logic [10:0] pinSync;
  logic [1:0] edgeLast;
  // Reset enters asynchronously, is released through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstOk <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstOk <= rstMeta;
    end
  end
  // Pins pass two flops; edge history reads only the second
  always_ff @(posedge core_clk or negedge rstOk) begin
    if (!rstOk) begin
      pinMeta <= 11'h7ff;
      pinSync <= 11'h7ff;
      edgeLast <= 2'h3;
    end else begin
      pinMeta <= {dioIn, goIn, stopPin, startPin};
      pinSync <= pinMeta;
      edgeLast <= pinSync[1:0];
    end
  end
  wire startFall = edgeLast[0] & ~pinSync[0];
  wire stopFall = edgeLast[1] & ~pinSync[1];
  wire goLevel = pinSync[2];
  wire [7:0] dioLevel = pinSync[10:3];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  msc_mode_t mode;
  logic quad;
  logic markEn;
  logic presetEn;
  logic goWatch;
  logic goDrive;
  logic goSet;
  logic goRst;
  logic [5:0] sel1;
  logic [5:0] sel2;
  logic [31:0] delay;
  logic [31:0] range;
  logic [31:0] preset;
  logic [15:0] dioMode;
  logic [7:0] dioReg;
  wire wrCtrl = bus.wr && bus.addr == A_CTRL;
  wire startCmd = wrCtrl & bus.wdata[C_START];
  wire haltCmd = wrCtrl & bus.wdata[C_HALT];
  wire wrStatus = bus.wr && bus.addr == A_STATUS;
  wire popReq = bus.rd && bus.addr == A_EVDATA;
  // Configuration writes; start and halt bits are not stored
  always_ff @(posedge core_clk or negedge rstOk) begin
    if (!rstOk) begin
      mode <= MODE_STOP;
      quad <= 1'b0;
      markEn <= 1'b0;
      presetEn <= 1'b0;
      goWatch <= 1'b0;
      goDrive <= 1'b0;
      goSet <= 1'b0;
      goRst <= 1'b0;
      sel1 <= 6'h00;
      sel2 <= 6'h00;
      delay <= 32'h0000_0000;
      range <= 32'h0000_0000;
      preset <= 32'h0000_0000;
      dioMode <= 16'h0000;
      dioReg <= 8'h00;
    end else if (bus.wr) begin
      case (bus.addr)
        A_CTRL: begin
          mode <= msc_mode_t'(bus.wdata[C_MODE +: 2]);
          quad <= bus.wdata[C_QUAD];
          markEn <= bus.wdata[C_MARK];
          presetEn <= bus.wdata[C_PREN];
          goWatch <= bus.wdata[C_GOWATCH];
          goDrive <= bus.wdata[C_GODRIVE];
          goSet <= bus.wdata[C_GOSET];
          goRst <= bus.wdata[C_GORST];
        end
        A_SYNC: begin
          sel1 <= bus.wdata[5:0];
          sel2 <= bus.wdata[13:8];
        end
        A_DELAY: delay <= bus.wdata;
        A_RANGE: range <= bus.wdata;
        A_PRESET: preset <= bus.wdata;
        A_DIOMODE: dioMode <= bus.wdata[15:0];
        A_DIOOUT: dioReg <= bus.wdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sweep sequencing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_SWEEP, ST_DEAD, ST_DRAIN
  } msc_state_t;
  msc_state_t state;
  logic measRun;
  logic [TMR_W-1:0] timer;
  logic [31:0] sweepCnt;
  logic [2:0] deadCnt;
  logic winOpenQ;
  logic seqDone;
  logic [7:0] cnt1;
  logic [14:0] cnt2;
  wire inSweep = state == ST_SWEEP;
  wire [31:0] tick16 = timer[36:5];
  wire [32:0] endPt = {1'b0, delay} + {1'b0, range};
  wire winOpen = tick16 >= delay;
  wire winClosed = {1'b0, tick16} >= endPt;
  wire wrapMode = mode == MODE_WRAP;
  wire goHalt = goWatch & ~goLevel;
  wire presetHit = presetEn & (&sweepCnt);
  // A start that also sets the enable must load the preset at once
  wire preNow = wrCtrl ? bus.wdata[C_PREN] : presetEn;
  wire [31:0] sweepInit = preNow ? ~preset : 32'h0000_0000;
  // Wrap mode needs no trigger edge once armed
  wire trig = startFall | wrapMode;
  wire sweepGo = state == ST_ARMED && trig && !presetHit;
  wire sweepEnd = inSweep & ~wrapMode & winClosed;
  wire drained = cnt1 == 8'h00 && cnt2 == 15'h0000;
  wire stopAll = haltCmd | goHalt;
  // Measurement state; halt from software or run line wins
  always_ff @(posedge core_clk or negedge rstOk) begin
    if (!rstOk) begin
      state <= ST_IDLE;
      measRun <= 1'b0;
      deadCnt <= 3'h0;
    end else if (stopAll) begin
      state <= ST_IDLE;
      measRun <= 1'b0;
    end else if (startCmd) begin
      state <= ST_ARMED;
      measRun <= 1'b1;
    end else begin
      case (state)
        ST_ARMED: if (sweepGo) state <= ST_SWEEP;
        ST_SWEEP: begin
          if (sweepEnd) begin
            state <= ST_DEAD;
            deadCnt <= 3'h0;
          end
        end
        ST_DEAD: begin
          deadCnt <= deadCnt + 3'h1;
          // Dead time stays within its bound before rearming
          if (deadCnt >= 3'(DEAD_LAST)) begin
            if (!presetHit) state <= ST_ARMED;
            else if (mode == MODE_SEQ) state <= ST_DRAIN;
            else begin
              state <= ST_IDLE;
              measRun <= 1'b0;
            end
          end
        end
        ST_DRAIN: if (drained) state <= ST_ARMED;
        default: state <= ST_IDLE;
      endcase
    end
  end
  // Timer runs through the sweep; wraps over its full width
  always_ff @(posedge core_clk or negedge rstOk) begin
    if (!rstOk) timer <= '0;
    else if (sweepGo) timer <= '0;
    else if (inSweep) timer <= timer + TMR_STEP;
  end
  // Counter loads on start, bumps at each real sweep start
  always_ff @(posedge core_clk or negedge rstOk) begin
    if (!rstOk) sweepCnt <= 32'h0000_0000;
    else if (startCmd && !stopAll) sweepCnt <= sweepInit;
    else if (state == ST_DRAIN && drained) sweepCnt <= sweepInit;
    else if (sweepGo) sweepCnt <= sweepCnt + 32'h1;
  end

  // ----------------------------------------------------------------
  // Event capture and two-stage buffer
  // ----------------------------------------------------------------
  msc_word_t mem1 [0:254];
  msc_word_t mem2 [0:16383];
  logic [7:0] wp1;
  logic [7:0] rp1;
  logic [13:0] wp2;
  logic [13:0] rp2;
  logic s1Sticky;
  logic s2Sticky;
  function automatic logic [7:0] step255(input logic [7:0] p);
    step255 = (p == S1_LAST) ? 8'h00 : p + 8'h01;
  endfunction
  wire s1Full = cnt1 == S1_FULL;
  wire s2Full = cnt2 == S2_FULL;
  wire markPush = sweepGo & markEn;
  // Stops before the delay never reach the buffer, nor stops past the window end outside wrap mode
  wire inWin = winOpen & (wrapMode | ~winClosed);
  wire stopPush = inSweep & stopFall & inWin;
  // 1 ns bins keep 31 bits, 2 ns bins keep 30
  wire [30:0] stamp = quad ? {1'b0, timer[31:2]} : timer[31:1];
  msc_word_t pushWord;
  assign pushWord = markPush ? msc_word_t'{1'b1, sweepCnt[30:0]}
                             : msc_word_t'{1'b0, stamp};
  wire push = markPush | stopPush;
  wire wr1 = push & ~s1Full;
  wire mv = cnt1 != 8'h00 && !s2Full;
  wire pop = popReq && cnt2 != 15'h0000;
  // Stage one: fast 255-entry ring
  always_ff @(posedge core_clk) begin
    if (wr1) mem1[wp1] <= pushWord;
  end
  // Stage two: large ring, drained by data register reads
  always_ff @(posedge core_clk) begin
    if (mv) mem2[wp2] <= mem1[rp1];
  end
  // Pointers and fill counts of both stages
  always_ff @(posedge core_clk or negedge rstOk) begin
    if (!rstOk) begin
      wp1 <= 8'h00;
      rp1 <= 8'h00;
      cnt1 <= 8'h00;
      wp2 <= 14'h0000;
      rp2 <= 14'h0000;
      cnt2 <= 15'h0000;
    end else begin
      if (wr1) wp1 <= step255(wp1);
      if (mv) rp1 <= step255(rp1);
      cnt1 <= cnt1 + {7'h00, wr1} - {7'h00, mv};
      if (mv) wp2 <= wp2 + 14'h0001;
      if (pop) rp2 <= rp2 + 14'h0001;
      cnt2 <= cnt2 + {14'h0000, mv} - {14'h0000, pop};
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge rstOk) begin
    if (!rstOk) begin
      s1Sticky <= 1'b0;
      s2Sticky <= 1'b0;
      seqDone <= 1'b0;
    end else begin
      s1Sticky <= s1Full |
        (s1Sticky & ~(wrStatus & bus.wdata[S_S1FULL]));
      s2Sticky <= s2Full |
        (s2Sticky & ~(wrStatus & bus.wdata[S_S2FULL]));
      seqDone <= (state == ST_DRAIN && drained) |
        (seqDone & ~(wrStatus & bus.wdata[S_SEQDONE]));
    end
  end

  // ----------------------------------------------------------------
  // SYNC sources
  // ----------------------------------------------------------------
  wire firstPls = inSweep & winOpen & ~winOpenQ;
  wire lastPls = sweepEnd;
  wire [26:0] taps = timer[TAP_LSB +: TAPS] & {TAPS{inSweep}};
  wire [63:0] srcVec = {sweepCnt, taps, s2Full, s1Full,
                        lastPls, firstPls, ~inSweep};
  function automatic logic pick(input logic [5:0] s,
                                input logic [63:0] v);
    pick = v[s];
  endfunction
  // Selected sources are registered so outputs come from flops
  always_ff @(posedge core_clk or negedge rstOk) begin
    if (!rstOk) begin
      winOpenQ <= 1'b0;
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      winOpenQ <= inSweep & winOpen;
      sync1 <= pick(sel1, srcVec);
      sync2 <= pick(sel2, srcVec);
    end
  end

  // ----------------------------------------------------------------
  // Run line and digital port
  // ----------------------------------------------------------------
  // Only ever pulls low; force-low beats force-release
  wire goPull = goRst | (goDrive & ~goSet & ~measRun);
  logic [7:0] next_dioOut;
  logic [7:0] next_dioOe;
  // Mode 0 input, 1 open-drain, 2 or 3 driven output
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_dioOut[i] = dioMode[2*i+1] & dioReg[i];
      next_dioOe[i] = dioMode[2*i+1] |
        (dioMode[2*i] & ~dioReg[i]);
    end
  end
  always_ff @(posedge core_clk or negedge rstOk) begin
    if (!rstOk) begin
      goOut <= 1'b0;
      goOe <= 1'b0;
      dioOut <= 8'h00;
      dioOe <= 8'h00;
    end else begin
      goOut <= 1'b0;
      goOe <= goPull;
      dioOut <= next_dioOut;
      dioOe <= next_dioOe;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  wire [31:0] ctrlRd = {21'h000000, goRst, goSet, goDrive, goWatch,
                        presetEn, markEn, quad, mode, 2'b00};
  wire [31:0] statRd = {24'h000000, goLevel, s2Full, s1Full, seqDone,
                        s2Sticky, s1Sticky, inSweep, measRun};
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        A_CTRL: next_rdata = ctrlRd;
        A_SYNC: next_rdata = {18'h00000, sel2, 2'b00, sel1};
        A_DELAY: next_rdata = delay;
        A_RANGE: next_rdata = range;
        A_PRESET: next_rdata = preset;
        A_SWEEPS: next_rdata = sweepCnt;
        A_STATUS: next_rdata = statRd;
        A_DIOMODE: next_rdata = {16'h0000, dioMode};
        A_DIOOUT: next_rdata = {24'h000000, dioReg};
        A_DIOIN: next_rdata = {24'h000000, dioLevel};
        A_EVDATA: next_rdata = pop ? mem2[rp2] : 32'h0000_0000;
        A_EVCOUNT: next_rdata = {8'h00, cnt1, 1'b0, cnt2};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Data stands one cycle, then returns to zero
  always_ff @(posedge core_clk or negedge rstOk) begin
    if (!rstOk) rdata <= 32'h0000_0000;
    else rdata <= next_rdata;
  end
endmodule // msc_core

// >>> include/msc_pkg.sv
// Constants and carrier types of the multiscaler sweep control.
// Assumes a 25 MHz core clock and a plain register port.
package msc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int DEAD_NS = 200;
  localparam int DEAD_CYC = (DEAD_NS / CLK_NS < 1) ? 1 : DEAD_NS / CLK_NS;
  localparam int DEAD_LAST = (DEAD_CYC > 1) ? DEAD_CYC - 2 : 0;
  // Timer counts half nanoseconds, so bit 5 toggles every 16 ns
  localparam int TMR_W = 37;
  localparam logic [36:0] TMR_STEP = 37'(2 * CLK_NS);
  localparam int TAP_LSB = 5;
  localparam int TAPS = 27;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] S1_LAST = 8'hfe;
  localparam logic [7:0] S1_FULL = 8'hff;
  localparam logic [14:0] S2_FULL = 15'h4000;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SYNC = 8'h04;
  localparam logic [7:0] A_DELAY = 8'h08;
  localparam logic [7:0] A_RANGE = 8'h0c;
  localparam logic [7:0] A_PRESET = 8'h10;
  localparam logic [7:0] A_SWEEPS = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_DIOMODE = 8'h1c;
  localparam logic [7:0] A_DIOOUT = 8'h20;
  localparam logic [7:0] A_DIOIN = 8'h24;
  localparam logic [7:0] A_EVDATA = 8'h28;
  localparam logic [7:0] A_EVCOUNT = 8'h2c;
  // CTRL fields
  localparam int C_START = 0;
  localparam int C_HALT = 1;
  localparam int C_MODE = 2;
  localparam int C_QUAD = 4;
  localparam int C_MARK = 5;
  localparam int C_PREN = 6;
  localparam int C_GOWATCH = 7;
  localparam int C_GODRIVE = 8;
  localparam int C_GOSET = 9;
  localparam int C_GORST = 10;
  // STATUS sticky fields, write one to clear
  localparam int S_S1FULL = 2;
  localparam int S_S2FULL = 3;
  localparam int S_SEQDONE = 4;
  // SYNC source codes
  localparam logic [5:0] SRC_TAP0 = 6'h05;
  localparam logic [5:0] SRC_SWP0 = 6'h20;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STOP, MODE_WRAP, MODE_SEQ, MODE_SPARE
  } msc_mode_t;
  typedef struct packed {
    logic marker;
    logic [30:0] stamp;
  } msc_word_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } msc_bus_t;
endpackage

// >>> test/msc_far.sv
// Far-side model: the shared run line and the eight I/O pins.
// Assumes the bench sets holdLow and extLow for the other equipment.
`timescale 1ns/1ps
module msc_far (
  input wire logic goOut,
  input wire logic goOe,
  input wire logic holdLow,
  input wire logic [7:0] dioOut,
  input wire logic [7:0] dioOe,
  input wire logic [7:0] extLow,
  output logic goIn,
  output logic [7:0] dioIn
);
  // Pull-ups on all lines; others only ever sink, so the run line is an AND
  assign goIn = (goOe ? goOut : 1'b1) & ~holdLow;
  assign dioIn = (dioOe & dioOut) | (~dioOe & ~extLow);
endmodule // msc_far

// >>> test/msc_core_asserts.sv
// Concurrent checks on the sweep control ports.
// Assumes software reaches CTRL, SYNC and the I/O registers only by bus.
`timescale 1ns/1ps
module msc_core_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire msc_pkg::msc_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic startPin,
  input wire logic goIn,
  input wire logic goOut,
  input wire logic goOe,
  input wire logic [7:0] dioOut,
  input wire logic [7:0] dioOe,
  input wire logic sync1,
  input wire logic sync2
);
  import msc_pkg::*;
  // ------------------------------------------------------------
  // Register mirrors
  // ------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] dioMode;
  logic [7:0] dioSet;
  logic [13:0] sel;
  logic [3:0] selAge;
  logic [3:0] startAge;
  logic [7:0] expOe;
  logic [7:0] drvMask;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Mirrors let outputs be tied to settings; ages saturate at 15
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= 32'h0;
      dioMode <= 16'h0;
      dioSet <= 8'h0;
      sel <= 14'h0;
      selAge <= 4'h0;
      startAge <= 4'hf;
    end else begin
      if (bus.wr && bus.addr == A_CTRL) ctrl <= bus.wdata;
      if (bus.wr && bus.addr == A_DIOMODE) dioMode <= bus.wdata[15:0];
      if (bus.wr && bus.addr == A_DIOOUT) dioSet <= bus.wdata[7:0];
      if (bus.wr && bus.addr == A_SYNC) sel <= bus.wdata[13:0];
      selAge <= (bus.wr && bus.addr == A_SYNC) ? 4'h0 :
        selAge + {3'h0, selAge != 4'hf};
      startAge <= $fell(startPin) ? 4'h0 : startAge + {3'h0, startAge != 4'hf};
    end
  end
  // Open-drain pins drive only a zero; driven pins always drive
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      drvMask[i] = dioMode[2*i+1];
      expOe[i] = dioMode[2*i+1] | (dioMode[2*i] & ~dioSet[i]);
    end
  end
  sequence quiet_s;
    !bus.wr [*3];
  endsequence
  sequence runSel_s;
    selAge > 4'd2 && sel[5:0] == 6'h00;
  endsequence
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data outside its slot");
  a_go_opendrain: assert property (goOe |-> !goOut)
    else $error("run line driven high");
  a_go_forced: assert property (quiet_s ##0 ctrl[C_GORST] |-> goOe)
    else $error("forced low run line released");
  a_go_free: assert property (quiet_s ##0 (!ctrl[C_GORST] &&
    !ctrl[C_GODRIVE]) |-> !goOe) else $error("run line pulled undriven");
  a_dio_enable: assert property (quiet_s |-> dioOe == expOe)
    else $error("pin enables disagree with mode");
  a_dio_level: assert property (quiet_s |->
    (dioOut & drvMask) == (dioSet & drvMask)) else $error("pin level wrong");
  a_start_edge: assert property (runSel_s ##0 ctrl[3:2] == 2'h0 &&
    $fell(sync1) |-> startAge inside {[1:6]}) else $error("sweep unprompted");
  a_close_pulse: assert property (selAge > 4'd2 && sel[5:0] == 6'h02 &&
    $rose(sync1) |=> !sync1) else $error("close pulse too long");
  a_open_pulse: assert property (selAge > 4'd2 && sel[13:8] == 6'h01 &&
    $rose(sync2) |=> !sync2) else $error("open pulse too long");
  a_go_halt: assert property ((sel[5:0] == 6'h00 && selAge > 4'd2 &&
    ctrl[C_GOWATCH] && !goIn) [*6] |-> sync1) else $error("no halt on line");
endmodule // msc_core_asserts
bind msc_core msc_core_asserts msc_core_asserts_i (.core_clk(core_clk),
  .rst_b(rst_b), .bus(bus), .rdata(rdata), .startPin(startPin),
  .goIn(goIn), .goOut(goOut), .goOe(goOe), .dioOut(dioOut),
  .dioOe(dioOe), .sync1(sync1), .sync2(sync2));

// >>> test/multiscaler_sweep_control_tb_top.sv
// Self-checking bench: register tasks, pin pulses and scenarios.
// Assumes msc_core, its checker and msc_far are compiled before it.
`timescale 1ns/1ps
module multiscaler_sweep_control_tb_top;
  import msc_pkg::*;
  logic core_clk, rst_b, startPin, stopPin, goIn, goOut, goOe, holdLow;
  logic sync1, sync2, last;
  logic [31:0] rdata, got;
  logic [7:0] dioIn, dioOut, dioOe, extLow;
  logic [32:0] goCase [5] = '{33'h100000100, 33'h000000300, 33'h100000400,
    33'h000000105, 33'h100000102};
  msc_bus_t bus;
  int fails, checks_done, tog;
  msc_core msc_core_i (.core_clk(core_clk), .rst_b(rst_b), .bus(bus),
    .rdata(rdata), .startPin(startPin), .stopPin(stopPin), .goIn(goIn),
    .goOut(goOut), .goOe(goOe), .dioIn(dioIn), .dioOut(dioOut),
    .dioOe(dioOe), .sync1(sync1), .sync2(sync2));
  msc_far msc_far_i (.goOut(goOut), .goOe(goOe), .holdLow(holdLow),
    .dioOut(dioOut), .dioOe(dioOe), .extLow(extLow), .goIn(goIn),
    .dioIn(dioIn));
  // ------------------------------------------------------------
  // Clock and tasks
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes last one cycle and are launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, got);
    chk(got, exp);
  endtask
  // Pins idle high; an event is a low pulse of several cycles
  task automatic fall(input bit isStart, input int low);
    @(posedge core_clk);
    startPin <= !isStart;
    stopPin <= isStart;
    repeat (low) @(posedge core_clk);
    startPin <= 1'b1;
    stopPin <= 1'b1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the under a thousand cycles the tests need
  initial begin
    #(40 * 20000);
    fails++;
    conclude();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    bus = '0;
    startPin = 1'b1;
    stopPin = 1'b1;
    holdLow = 1'b0;
    extLow = 8'h01;
    fails = 0;
    checks_done = 0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    rc(A_STATUS, 32'h80);
    rc(A_SWEEPS, 32'h0);
    rc(A_EVCOUNT, 32'h0);
    rc(8'h3c, 32'h0);
    $display("test reset done");
    // Stop mode, preset of two, markers on; third start must be blocked
    wr(A_RANGE, 32'h28);
    wr(A_PRESET, 32'h2);
    wr(A_SYNC, 32'h0100);
    wr(A_CTRL, 32'h61);
    rc(A_SWEEPS, 32'hfffffffd);
    fall(1, 8);
    fall(0, 2);
    repeat (14) @(posedge core_clk);
    fall(1, 8);
    repeat (14) @(posedge core_clk);
    fall(0, 2);
    fall(1, 8);
    fall(0, 2);
    repeat (10) @(posedge core_clk);
    rc(A_SWEEPS, 32'hffffffff);
    rc(A_EVCOUNT, 32'h3);
    rc(A_EVDATA, 32'hfffffffd);
    rd(A_EVDATA, got);
    chk(32'(!got[31] && got[30:0] >= 31'hc8 && got[30:0] <= 31'h1f4), 1);
    rc(A_EVDATA, 32'hfffffffe);
    $display("test stop mode done");
    // Wrap mode without preset, sweep bits then run level and a tap
    wr(A_CTRL, 32'h2);
    wr(A_CTRL, 32'h5);
    wr(A_SYNC, 32'h2120);
    repeat (4) @(posedge core_clk);
    chk(sync1, 1'b1);
    chk(sync2, 1'b0);
    rc(A_SWEEPS, 32'h1);
    wr(A_SYNC, 32'h0800);
    repeat (40) @(posedge core_clk);
    rc(A_STATUS, 32'h83);
    chk(sync1, 1'b0);
    tog = 0;
    for (int i = 0; i < 400; i++) begin
      last = sync2;
      @(negedge core_clk);
      tog += int'(sync2 !== last);
    end
    chk(32'(tog >= 123 && tog <= 127), 1);
    $display("test wrap mode done");
    // Run line: watched halt, then drive and force settings
    wr(A_CTRL, 32'h84);
    holdLow <= 1'b1;
    repeat (8) @(posedge core_clk);
    rc(A_STATUS, 32'h0);
    chk(sync1, 1'b1);
    holdLow <= 1'b0;
    last = sync2;
    repeat (20) @(posedge core_clk);
    chk(sync2, last);
    foreach (goCase[i]) begin
      wr(A_CTRL, goCase[i][31:0]);
      repeat (3) @(posedge core_clk);
      chk(goOe, goCase[i][32]);
    end
    wr(A_CTRL, 32'h0);
    $display("test run line done");
    // Sequential mode, preset of one: reload and rearm after each sequence
    wr(A_PRESET, 32'h1);
    wr(A_SYNC, 32'h0002);
    wr(A_CTRL, 32'h49);
    fall(1, 8);
    repeat (40) @(posedge core_clk);
    rc(A_SWEEPS, 32'hfffffffe);
    rd(A_STATUS, got);
    chk(got & 32'h10, 32'h10);
    wr(A_STATUS, 32'h10);
    rd(A_STATUS, got);
    chk(got & 32'h10, 32'h0);
    fall(1, 8);
    repeat (6) @(posedge core_clk);
    rc(A_SWEEPS, 32'hffffffff);
    wr(A_CTRL, 32'h2);
    // Four-input bins: same stop spacing as before, 320 ns in 2 ns bins
    wr(A_CTRL, 32'h11);
    fall(1, 8);
    fall(0, 2);
    repeat (4) @(posedge core_clk);
    rc(A_EVDATA, 32'ha0);
    wr(A_CTRL, 32'h2);
    $display("test sequential mode done");
    // Pins 0-1 input, 2-3 open-drain, 4-7 driven; far side sinks pin 0
    wr(A_DIOMODE, 32'haa50);
    wr(A_DIOOUT, 32'ha5);
    repeat (4) @(posedge core_clk);
    chk(dioOe, 8'hf8);
    rc(A_DIOIN, 32'ha6);
    $display("test io port done");
    conclude();
  end
endmodule // multiscaler_sweep_control_tb_top
